// >>> design/lmp_pkg.sv
// list-mode word packer: shared constants, word layouts and types
// assumes one 250 MHz core clock; no software-visible registers
package lmp_pkg;
	// core clock period and derived timing
	localparam int CLK_PERIOD_NS = 4;
	localparam int TICK_NS = 80; // prescaler tick
	localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STAMP_MS = 10; // time-stamp period
	localparam int STAMP_TICKS = (STAMP_MS * 1000000) / TICK_NS;
	// counter widths
	localparam int PRESC_W = 18;
	localparam int TIME_W = 30;
	localparam int CONV_W = 12;
	// word tags in bits 31:30
	localparam logic [1:0] TAG_SYNC = 2'h0;
	localparam logic [1:0] TAG_LIVE = 2'h1;
	localparam logic [1:0] TAG_REAL = 2'h2;
	localparam logic [1:0] TAG_PEAK = 2'h3;
	// field positions inside the 30-bit body
	localparam int PEAK_ROUTE_POS = 29;
	localparam int PEAK_PRESC_LSB = 12;
	localparam int SYNC_REAL_LSB = 17;
	localparam int SYNC_REAL_W = 13;
	// fifo defaults
	localparam int FIFO_DEPTH = 16;
	localparam int WORD_W = 32;
	localparam int HALF_W = 16;
	// reset values
	localparam logic [TIME_W-1:0] TIME_RST = 30'h0;
	localparam logic [PRESC_W-1:0] PRESC_RST = 18'h0;
	// one output word
	typedef struct packed {
		logic [1:0] tag;
		logic [TIME_W-1:0] body;
	} lmp_word_type;
	// one peak event from the pulse processor
	typedef struct packed {
		logic route;
		logic [CONV_W-1:0] conv;
	} lmp_peak_type;
	// selector state
	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_LIVE = 1'b1
	} lmp_state_type;
endpackage

// >>> design/lmp_fifo.sv
// list-mode word packer: flip-flop fifo with valid/ready on both sides
// assumes push and pop happen on the one core clock
`timescale 1ns/1ns
module lmp_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	// fill side
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	// drain side
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH]; // storage
	logic [AW-1:0] wr_q; // write index
	logic [AW-1:0] rd_q; // read index
	logic [AW:0] cnt_q; // fill level
	wire push_w = i_in_valid && o_in_ready;
	wire pop_w = o_out_valid && i_out_ready;
	assign o_in_ready = (cnt_q != (AW+1)'(DEPTH));
	assign o_out_valid = (cnt_q != '0);
	assign o_out_data = mem_q[rd_q];
	// pointers and level
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push_w) wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
			if (pop_w) rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
			cnt_q <= cnt_q + (AW+1)'(push_w) - (AW+1)'(pop_w);
		end
	end
	// storage write
	always_ff @(posedge i_core_clk) begin
		if (push_w) mem_q[wr_q] <= i_in_data;
	end
endmodule

// >>> design/lmp_half_ser.sv
// list-mode word packer: splits 32-bit words into 16-bit halves
// assumes the reader takes one half per cycle when ready is high
`timescale 1ns/1ns
module lmp_half_ser (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	// word side
	input wire logic i_word_valid,
	output logic o_word_ready,
	input wire logic [31:0] i_word,
	// half side
	output logic o_half_valid,
	input wire logic i_half_ready,
	output logic [15:0] o_half
);
	logic full_q; // a half is on offer
	logic hi_q; // the offered half is the upper one
	logic [15:0] half_q; // offered half
	logic [15:0] upper_q; // upper half kept back
	wire take_w = full_q && i_half_ready;
	assign o_half_valid = full_q;
	assign o_half = half_q;
	assign o_word_ready = !full_q || (take_w && hi_q);
	// low half first, then upper half
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			full_q <= 1'b0;
			hi_q <= 1'b0;
			half_q <= 16'h0;
			upper_q <= 16'h0;
		end else if (i_word_valid && o_word_ready) begin
			full_q <= 1'b1;
			hi_q <= 1'b0;
			half_q <= i_word[15:0];
			upper_q <= i_word[31:16];
		end else if (take_w) begin
			full_q <= !hi_q;
			hi_q <= 1'b1;
			half_q <= upper_q;
		end
	end
	// the upper half always follows a taken lower half
	property p_half_order;
		@(posedge i_core_clk) disable iff (i_sys_rst)
		(take_w && !hi_q) |=> (full_q && hi_q && half_q == $past(upper_q));
	endproperty
	a_half_order: assert property (p_half_order) else $error("upper half did not follow lower half");
endmodule

// >>> design/lmp_packer.sv
// list-mode word packer: builds tagged 32-bit words from peak events,
// periodic real/live time stamps and external sync stamps, and streams
// them as 16-bit halves to the host readout path.
// assumes the pulse processor, sync input and live gate are synchronous
// to i_core_clk; the host reads by dma handshake or the fast port.
// Notes on behaviour
// - stream every event at once, never histogram
// - each event carries pulse height and arrival time
// - 32-bit words sent as 16-bit halves, low first
// - host reads via dma or fast read port
// - peak word: tag 3, route, prescaler, conversion
// - every 10 ms emit real then live stamp
// - sync pulse emits tag 0 sync-stamp word
// - sync real and prescaler are separate fields
// - sync stamp latches timebase at pulse instant
`timescale 1ns/1ns
module lmp_packer #(
	parameter int STAMP_TICKS = lmp_pkg::STAMP_TICKS, // 80 ns ticks per time stamp
	parameter int FIFO_DEPTH = lmp_pkg::FIFO_DEPTH
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	// peak events from the pulse processor
	input wire logic i_peak_valid,
	output logic o_peak_ready,
	input wire lmp_pkg::lmp_peak_type i_peak,
	// timebase control
	input wire logic i_live_gate,
	input wire logic i_sync_in,
	// host readout
	input wire logic i_dma_mode,
	input wire logic i_dma_ack,
	output logic o_dma_req,
	input wire logic i_fast_readout_port_rd,
	output logic o_fast_readout_port_valid,
	output logic [15:0] o_fast_readout_port
);
	localparam int TW = $clog2(lmp_pkg::TICK_CYCLES);

	// timebase registers
	logic [TW-1:0] tick_q; // core cycles inside one 80 ns tick
	logic [lmp_pkg::PRESC_W-1:0] presc_q; // 80 ns ticks inside one stamp period
	logic [lmp_pkg::TIME_W-1:0] real_q; // real time in stamp periods
	logic [lmp_pkg::TIME_W-1:0] live_q; // live time in stamp periods
	logic sync_prev_q; // previous sync level for edge detect

	// pending words
	logic ts_pend_q; // time-stamp pair due
	logic sync_pend_q; // sync stamp due
	logic peak_pend_q; // peak word captured
	lmp_pkg::lmp_word_type real_word_q; // latched real-time word
	lmp_pkg::lmp_word_type live_word_q; // latched live-time word
	lmp_pkg::lmp_word_type sync_word_q; // latched sync word
	lmp_pkg::lmp_word_type peak_word_q; // latched peak word
	lmp_pkg::lmp_state_type state_q;
	lmp_pkg::lmp_state_type state_d;

	// timebase decode
	wire tick_w = (tick_q == TW'(lmp_pkg::TICK_CYCLES - 1));
	wire stamp_due_w = tick_w && (presc_q == lmp_pkg::PRESC_W'(STAMP_TICKS - 1));
	wire sync_edge_w = i_sync_in && !sync_prev_q;
	wire peak_take_w = i_peak_valid && o_peak_ready;

	// fifo connections
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [31:0] fifo_out_data;
	logic ser_word_ready;
	logic ser_half_valid;
	logic [15:0] ser_half;
	lmp_pkg::lmp_word_type push_word;
	logic push_valid;

	// builds a peak word from an event and the current prescaler
	function automatic lmp_pkg::lmp_word_type peak_word(input lmp_pkg::lmp_peak_type pk,
		input logic [lmp_pkg::PRESC_W-1:0] ps);
		lmp_pkg::lmp_word_type w;
		w.tag = lmp_pkg::TAG_PEAK;
		w.body = {pk.route, ps[lmp_pkg::PRESC_W-1:1], pk.conv};
		return w;
	endfunction

	// builds a sync word: two separate fields, not one count
	function automatic lmp_pkg::lmp_word_type sync_word(input logic [lmp_pkg::TIME_W-1:0] rt,
		input logic [lmp_pkg::PRESC_W-1:0] ps);
		lmp_pkg::lmp_word_type w;
		w.tag = lmp_pkg::TAG_SYNC;
		w.body = {rt[lmp_pkg::SYNC_REAL_W-1:0], ps[lmp_pkg::PRESC_W-1:1]};
		return w;
	endfunction

	// core-cycle and prescaler counters
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			tick_q <= '0;
			presc_q <= lmp_pkg::PRESC_RST;
		end else begin
			tick_q <= tick_w ? '0 : tick_q + 1'b1;
			if (stamp_due_w) presc_q <= lmp_pkg::PRESC_RST;
			else if (tick_w) presc_q <= presc_q + 1'b1;
		end
	end

	// real time advanced once per stamp period, live time only when i_live_gate is high
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			real_q <= lmp_pkg::TIME_RST;
			live_q <= lmp_pkg::TIME_RST;
		end else if (stamp_due_w) begin
			real_q <= real_q + 1'b1;
			if (i_live_gate) live_q <= live_q + 1'b1;
		end
	end

	// time-stamp pair capture; set wins over the clear
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			ts_pend_q <= 1'b0;
			real_word_q <= '0;
			live_word_q <= '0;
		end else if (stamp_due_w) begin
			ts_pend_q <= 1'b1;
			real_word_q <= {lmp_pkg::TAG_REAL, real_q + 1'b1};
			live_word_q <= {lmp_pkg::TAG_LIVE, i_live_gate ? live_q + 1'b1 : live_q};
		end else if (state_q == lmp_pkg::ST_LIVE && fifo_in_ready) begin
			ts_pend_q <= 1'b0;
		end
	end

	// sync stamp capture at the pulse instant
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			sync_prev_q <= 1'b0;
			sync_pend_q <= 1'b0;
			sync_word_q <= '0;
		end else begin
			sync_prev_q <= i_sync_in;
			if (sync_edge_w) begin
				sync_pend_q <= 1'b1;
				sync_word_q <= sync_word(real_q, presc_q);
			end else if (state_d == lmp_pkg::ST_IDLE && state_q == lmp_pkg::ST_IDLE && !ts_pend_q
				&& fifo_in_ready) begin
				sync_pend_q <= 1'b0;
			end
		end
	end

	// peak capture with arrival time
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			peak_pend_q <= 1'b0;
			peak_word_q <= '0;
		end else if (peak_take_w) begin
			peak_pend_q <= 1'b1;
			peak_word_q <= peak_word(i_peak, presc_q);
		end else if (state_q == lmp_pkg::ST_IDLE && !ts_pend_q && !sync_pend_q && fifo_in_ready) begin
			peak_pend_q <= 1'b0;
		end
	end

	// a new event waits only while the previous one is still held
	assign o_peak_ready = !peak_pend_q;

	// fixed order: time-stamp pair, then sync, then peak
	assign push_valid = (state_q == lmp_pkg::ST_LIVE) || ts_pend_q || sync_pend_q || peak_pend_q;
	assign push_word = (state_q == lmp_pkg::ST_LIVE) ? live_word_q :
		ts_pend_q ? real_word_q :
		sync_pend_q ? sync_word_q : peak_word_q;

	// selector state: the live word always follows the real word
	always_comb begin
		state_d = state_q;
		case (state_q)
			lmp_pkg::ST_IDLE: begin
				if (ts_pend_q && fifo_in_ready) state_d = lmp_pkg::ST_LIVE;
			end
			lmp_pkg::ST_LIVE: begin
				if (fifo_in_ready) state_d = lmp_pkg::ST_IDLE;
			end
			default: begin
				state_d = lmp_pkg::ST_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) state_q <= lmp_pkg::ST_IDLE;
		else state_q <= state_d;
	end

	// output word buffer
	lmp_fifo #(
		.WIDTH(lmp_pkg::WORD_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.i_core_clk(i_core_clk),
		.i_sys_rst(i_sys_rst),
		.i_in_valid(push_valid),
		.o_in_ready(fifo_in_ready),
		.i_in_data(push_word),
		.o_out_valid(fifo_out_valid),
		.i_out_ready(ser_word_ready),
		.o_out_data(fifo_out_data)
	);

	// host takes a half by dma acknowledge or by fast-port read
	wire half_ready_w = i_dma_mode ? i_dma_ack : i_fast_readout_port_rd;

	// split into little-endian halves
	lmp_half_ser u_ser (
		.i_core_clk(i_core_clk),
		.i_sys_rst(i_sys_rst),
		.i_word_valid(fifo_out_valid),
		.o_word_ready(ser_word_ready),
		.i_word(fifo_out_data),
		.o_half_valid(ser_half_valid),
		.i_half_ready(half_ready_w),
		.o_half(ser_half)
	);

	// readout outputs
	assign o_dma_req = ser_half_valid && i_dma_mode;
	assign o_fast_readout_port_valid = ser_half_valid && !i_dma_mode;
	assign o_fast_readout_port = ser_half;

	// helper: pushes into the fifo
	wire push_w = push_valid && fifo_in_ready;

	property p_ts_pair;
		@(posedge i_core_clk) disable iff (i_sys_rst)
		(push_w && push_word.tag == lmp_pkg::TAG_REAL) |=> (state_q == lmp_pkg::ST_LIVE && push_word.tag == lmp_pkg::TAG_LIVE);
	endproperty
	a_ts_pair: assert property (p_ts_pair) else $error("real stamp not followed by live stamp");

	property p_stamp_pending;
		@(posedge i_core_clk) disable iff (i_sys_rst)
		stamp_due_w |=> (ts_pend_q && real_word_q.body == $past(real_q) + 1'b1);
	endproperty
	a_stamp_pending: assert property (p_stamp_pending) else $error("time stamp not raised");

	property p_peak_word;
		@(posedge i_core_clk) disable iff (i_sys_rst)
		peak_take_w |=> (peak_word_q.tag == 2'h3 && peak_word_q.body[11:0] == $past(i_peak.conv)
			&& peak_word_q.body[28:12] == $past(presc_q[17:1]) && peak_word_q.body[29] == $past(i_peak.route));
	endproperty
	a_peak_word: assert property (p_peak_word) else $error("peak word fields wrong");

	property p_sync_word;
		@(posedge i_core_clk) disable iff (i_sys_rst)
		sync_edge_w |=> (sync_pend_q && sync_word_q.tag == 2'h0 && sync_word_q.body[29:17] == $past(real_q[12:0])
			&& sync_word_q.body[16:0] == $past(presc_q[17:1]));
	endproperty
	a_sync_word: assert property (p_sync_word) else $error("sync word not latched");

	property p_peak_kept;
		@(posedge i_core_clk) disable iff (i_sys_rst)
		(peak_pend_q && (ts_pend_q || sync_pend_q || state_q == lmp_pkg::ST_LIVE || !fifo_in_ready)) |=> peak_pend_q;
	endproperty
	a_peak_kept: assert property (p_peak_kept) else $error("peak dropped");

	property p_order;
		@(posedge i_core_clk) disable iff (i_sys_rst)
		(push_w && ts_pend_q && state_q == lmp_pkg::ST_IDLE) |-> push_word.tag == lmp_pkg::TAG_REAL;
	endproperty
	a_order: assert property (p_order) else $error("stamp pair not given priority");

	property p_peak_ready;
		@(posedge i_core_clk) disable iff (i_sys_rst)
		peak_take_w |=> !o_peak_ready;
	endproperty
	a_peak_ready: assert property (p_peak_ready) else $error("peak ready not lowered");

	property p_half_route;
		@(posedge i_core_clk) disable iff (i_sys_rst)
		i_dma_mode |-> (o_dma_req == ser_half_valid && !o_fast_readout_port_valid);
	endproperty
	a_half_route: assert property (p_half_route) else $error("readout path mismatch");

	property p_presc_wrap;
		@(posedge i_core_clk) disable iff (i_sys_rst)
		stamp_due_w |=> (presc_q == '0 && real_q == $past(real_q) + 1'b1);
	endproperty
	a_presc_wrap: assert property (p_presc_wrap) else $error("timebase did not wrap");

	// live stamp carries the gate level sampled at the period end
	property p_live_word;
		@(posedge i_core_clk) disable iff (i_sys_rst)
		stamp_due_w |=> (live_word_q.tag == lmp_pkg::TAG_LIVE
			&& live_word_q.body == $past(live_q) + {29'h0, $past(i_live_gate)});
	endproperty
	a_live_word: assert property (p_live_word) else $error("live stamp value wrong");

	// a pushed peak frees the event input in the next cycle
	property p_peak_release;
		@(posedge i_core_clk) disable iff (i_sys_rst)
		(push_w && push_word.tag == lmp_pkg::TAG_PEAK) |=> o_peak_ready;
	endproperty
	a_peak_release: assert property (p_peak_release) else $error("peak input not freed after push");

	// a waiting sync stamp survives a stamp pair or a full buffer
	property p_sync_kept;
		@(posedge i_core_clk) disable iff (i_sys_rst)
		(sync_pend_q && (ts_pend_q || state_q == lmp_pkg::ST_LIVE || !fifo_in_ready)) |=> sync_pend_q;
	endproperty
	a_sync_kept: assert property (p_sync_kept) else $error("sync stamp dropped");

	c_ts: cover property (@(posedge i_core_clk) disable iff (i_sys_rst) push_w && push_word.tag == lmp_pkg::TAG_LIVE);
	c_sync: cover property (@(posedge i_core_clk) disable iff (i_sys_rst) push_w && push_word.tag == lmp_pkg::TAG_SYNC);
	c_clash: cover property (@(posedge i_core_clk) disable iff (i_sys_rst) ts_pend_q && sync_pend_q && peak_pend_q);
	c_full: cover property (@(posedge i_core_clk) disable iff (i_sys_rst) push_valid && !fifo_in_ready);
endmodule

// >>> tb/lmp_host_model.sv
// host readout model: takes 16-bit halves by dma handshake or fast port
// assumes one core clock; rebuilt words pulse o_word_valid for one cycle
`timescale 1ns/1ns
module lmp_host_model (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	// packer readout side
	input wire logic i_dma_mode,
	input wire logic i_dma_req,
	input wire logic i_port_valid,
	input wire logic [15:0] i_half,
	output logic o_dma_ack,
	output logic o_port_rd,
	// bench side: 0 prompt, 1 random stalls, 2 stopped
	input wire logic [1:0] i_stall,
	output logic o_word_valid,
	output logic [31:0] o_word
);
	logic have_low_q; // low half already held
	logic [15:0] low_q; // held low half
	logic go; // accept in the coming cycle
	int seed = 32'h0e622eb1;
	wire take = (o_dma_ack && i_dma_req) || (o_port_rd && i_port_valid);
	// take halves, low first, and pair them into words
	always @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			have_low_q <= 1'b0;
			low_q <= 16'h0;
			o_dma_ack <= 1'b0;
			o_port_rd <= 1'b0;
			o_word_valid <= 1'b0;
			o_word <= 32'h0;
		end else begin
			o_word_valid <= 1'b0;
			if (take) begin
				if (have_low_q) begin
					o_word <= {i_half, low_q};
					o_word_valid <= 1'b1;
				end else begin
					low_q <= i_half;
				end
				have_low_q <= !have_low_q;
			end
			go = (i_stall == 2'h0) || (i_stall == 2'h1 && ($random(seed) & 1) == 1);
			// one of the two readout paths, by mode
			o_dma_ack <= go && i_dma_mode;
			o_port_rd <= go && !i_dma_mode;
		end
	end
endmodule

// >>> tb/tb_top.sv
// packer testbench: random peaks, sync pulses, live gate and host stalls
// assumes the packer and host model files are compiled first
`timescale 1ns/1ns
module tb_top;
	localparam int STAMP_T = 50; // shortened stamp period in ticks
	localparam int TC = lmp_pkg::TICK_CYCLES; // cycles per tick
	localparam int PER = STAMP_T * TC; // cycles per stamp
	logic i_core_clk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic i_peak_valid = 1'b0;
	lmp_pkg::lmp_peak_type i_peak = 13'h0;
	logic i_live_gate = 1'b1;
	logic i_sync_in = 1'b0;
	logic i_dma_mode = 1'b0;
	logic [1:0] stall = 2'h0;
	logic o_peak_ready, o_dma_req, o_fast_readout_port_valid, i_dma_ack, i_fast_readout_port_rd, word_valid;
	logic [15:0] o_fast_readout_port;
	lmp_pkg::lmp_word_type word;
	int err_total = 0, n_checks = 0, cyc = 0, n_real = 0, exp_live = 0;
	int seed = 32'h0e622eb1;
	logic gate_cur = 1'b1, want_live = 1'b0;
	logic [31:0] exp_q[$], mask_q[$]; // peak and sync words in order

	lmp_packer #(.STAMP_TICKS(STAMP_T), .FIFO_DEPTH(16)) i_dut (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
		.i_peak_valid(i_peak_valid), .o_peak_ready(o_peak_ready), .i_peak(i_peak), .i_live_gate(i_live_gate),
		.i_sync_in(i_sync_in), .i_dma_mode(i_dma_mode), .i_dma_ack(i_dma_ack), .o_dma_req(o_dma_req),
		.i_fast_readout_port_rd(i_fast_readout_port_rd), .o_fast_readout_port_valid(o_fast_readout_port_valid),
		.o_fast_readout_port(o_fast_readout_port));
	lmp_host_model i_host (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_dma_mode(i_dma_mode),
		.i_dma_req(o_dma_req), .i_port_valid(o_fast_readout_port_valid), .i_half(o_fast_readout_port),
		.o_dma_ack(i_dma_ack), .o_port_rd(i_fast_readout_port_rd), .i_stall(stall), .o_word_valid(word_valid),
		.o_word(word));

	always #2 i_core_clk = ~i_core_clk;

	// cycles since reset release
	always @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) cyc <= 0;
		else cyc <= cyc + 1;
	end

	function automatic logic [31:0] r32();
		return $random(seed);
	endfunction

	// prescaler field expected at a given cycle
	function automatic logic [16:0] ps_field(input int c);
		return 17'(((c / TC) % STAMP_T) >> 1);
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
			err_total++;
		end
	endtask

	task automatic test_done();
		if (err_total == 0 && n_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	// offer n events; gap below zero draws a random gap, zero keeps valid up
	task automatic send_peaks(input int n, input int gap);
		lmp_pkg::lmp_peak_type p;
		logic [31:0] r;
		int w, c, g;
		for (int k = 0; k < n; k++) begin
			r = r32();
			p = (k == 0) ? 13'h1fff : (k == 1) ? 13'h0000 : r[12:0];
			i_peak_valid <= 1'b1;
			i_peak <= p;
			w = 0;
			do begin
				@(posedge i_core_clk);
				w++;
			end while (o_peak_ready !== 1'b1 && w < 3000);
			if (w >= 3000) chk(32'h0, 32'h1);
			c = cyc;
			exp_q.push_back({lmp_pkg::TAG_PEAK, p.route, ps_field(c), p.conv});
			// the time field is exact: it is the prescaler seen at the take edge
			mask_q.push_back(32'hffffffff);
			g = (gap < 0) ? int'(r[19:16]) : gap;
			if (g > 0 || k == n - 1) begin
				i_peak_valid <= 1'b0;
				repeat ((g == 0) ? 1 : g) @(posedge i_core_clk); // an edge passes before the next call
			end
		end
	endtask

	// one-cycle sync pulse mid-field and away from a stamp
	task automatic send_sync();
		int c;
		do @(posedge i_core_clk);
		while ((cyc + 1) % (2 * TC) != TC || (cyc + 1) % PER < 100 || (cyc + 1) % PER > PER - 100);
		c = cyc + 1;
		exp_q.push_back({lmp_pkg::TAG_SYNC, 13'(c / PER), ps_field(c)});
		mask_q.push_back(32'hffffffff);
		i_sync_in <= 1'b1;
		@(posedge i_core_clk);
		i_sync_in <= 1'b0;
	endtask

	// judge every word that the host rebuilds
	always @(posedge i_core_clk) begin
		if (word_valid) begin
			if (word.tag !== lmp_pkg::TAG_LIVE) chk(32'(want_live), 32'h0);
			case (word.tag)
				lmp_pkg::TAG_REAL: begin
					n_real++;
					exp_live += int'(gate_cur);
					chk({2'h0, word.body}, 32'(n_real));
					want_live = 1'b1;
					gate_cur = r32() > 32'h40000000;
					i_live_gate <= gate_cur;
				end
				lmp_pkg::TAG_LIVE: begin
					chk(32'(want_live), 32'h1);
					chk({2'h0, word.body}, 32'(exp_live));
					want_live = 1'b0;
				end
				default: begin
					if (exp_q.size() == 0) chk(word, ~word);
					else begin
						chk(word & mask_q[0], exp_q[0] & mask_q[0]);
						void'(exp_q.pop_front());
						void'(mask_q.pop_front());
					end
				end
			endcase
		end
	end

	// main sequence
	initial begin
		int w;
		repeat (16) @(posedge i_core_clk);
		chk(32'(o_peak_ready), 32'h1);
		chk({30'h0, o_dma_req, o_fast_readout_port_valid}, 32'h0);
		i_sys_rst <= 1'b0;
		// fast port, prompt host
		send_peaks(30, -1);
		send_sync();
		send_peaks(20, 0);
		// dma, host stopped: fifo fills, source held off, nothing lost
		i_dma_mode <= 1'b1;
		stall <= 2'h2;
		fork
			send_peaks(24, 0);
			begin
				repeat (300) @(posedge i_core_clk);
				chk(32'(o_peak_ready), 32'h0);
				stall <= 2'h0;
			end
		join
		// random host stalls in both modes
		stall <= 2'h1;
		repeat (3) begin
			send_peaks(15, -1);
			send_sync();
		end
		i_dma_mode <= 1'b0;
		send_peaks(15, -1);
		stall <= 2'h0;
		w = 0;
		while (exp_q.size() != 0 && w < 3000) begin
			@(posedge i_core_clk);
			w++;
		end
		chk(exp_q.size(), 32'h0);
		do @(posedge i_core_clk);
		while (cyc % PER != PER / 2);
		chk(32'(n_real), 32'(cyc / PER));
		test_done();
	end

	// cut a hang short
	initial begin
		repeat (60000) @(posedge i_core_clk);
		err_total++;
		test_done();
	end
endmodule
